// ===== edge_detect_pkg.sv
// Notes on behaviour
// - detect programmed edges on three pins, forward each as interrupt request
// - detection never stops, whatever the power or standby state; here it freezes while CE is low
// - reset clears both edge enable registers to zero
// - enable registers take single-bit and whole-byte reads and writes
// - rise/fall bit pair: 00 off, 01 fall, 10 rise, 11 both
// - bits 4, 5 and 7 steer pins a, b and c
// - no analog noise filter; recognition starts right after the input buffer
// - pin a request: maskable, default priority 1, vector 0008, word 0FE08
// - pin b request: maskable, default priority 2, vector 000A, word 0FE0A
// - maskable vectored requests nest over four programmable priority levels
// - pin c request: maskable, default priority 3, vector 000C, word 0FE0C
// - equal programmed priority: lower default priority number served first
package edge_detect_pkg;
  localparam logic [15:0] RISE_EN_ADDR   = 16'hffa0;
  localparam logic [15:0] FALL_EN_ADDR   = 16'hffa2;
  localparam logic [7:0]  EN_RESET       = 8'h00;
  localparam logic [7:0]  EN_USED_MASK   = 8'hb0;
  localparam int          NUM_PINS       = 3;
  localparam int          PIN_A_BIT      = 4;
  localparam int          PIN_B_BIT      = 5;
  localparam int          PIN_C_BIT      = 7;
  localparam logic [2:0]  DEF_PRIO_A     = 3'h1;
  localparam logic [2:0]  DEF_PRIO_B     = 3'h2;
  localparam logic [2:0]  DEF_PRIO_C     = 3'h3;
  localparam logic [15:0] VECTOR_A       = 16'h0008;
  localparam logic [15:0] VECTOR_B       = 16'h000a;
  localparam logic [15:0] VECTOR_C       = 16'h000c;
  localparam logic [19:0] MSCW_A         = 20'h0_fe08;
  localparam logic [19:0] MSCW_B         = 20'h0_fe0a;
  localparam logic [19:0] MSCW_C         = 20'h0_fe0c;
  localparam int          PRIO_LEVELS    = 4;
  localparam logic [2:0]  SYNC_RESET     = 3'h0;
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_RISE = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;
endpackage

// ===== pin_edge_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_unit (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         pin,
  input  wire edge_detect_pkg::edge_mode_t  mode,
  output logic                              hit
);
  import edge_detect_pkg::*;
  // three stages; only stage 0 feeds stage 1, the compared pair is 1 and 2
  logic [2:0] sync_r;
  wire rise_seen = sync_r[1] & ~sync_r[2];
  wire fall_seen = ~sync_r[1] & sync_r[2];
  wire rise_ok   = (mode == EDGE_RISE) | (mode == EDGE_BOTH);
  wire fall_ok   = (mode == EDGE_FALL) | (mode == EDGE_BOTH);
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_r <= SYNC_RESET;
    end else if (ce) begin
      sync_r <= {sync_r[1:0], pin};
    end
  end
  assign hit = (rise_seen & rise_ok) | (fall_seen & fall_ok);
endmodule
`default_nettype wire

// ===== edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic [15:0]           ADDR,
  input  wire logic                  WR,
  input  wire logic                  RD,
  input  wire logic                  BIT_OP,
  input  wire logic [2:0]            BIT_SEL,
  input  wire logic [7:0]            WDATA,
  output logic      [7:0]            RDATA,
  input  wire logic                  PORT_PIN_A,
  input  wire logic                  PORT_PIN_B,
  input  wire logic                  PORT_PIN_C,
  output logic                       EXT_IRQ_A,
  output logic                       EXT_IRQ_B,
  output logic                       EXT_IRQ_C,
  output logic      [2:0]            IRQ_DEF_PRIO,
  output logic      [15:0]           IRQ_VECTOR,
  output logic      [19:0]           IRQ_MSCW
);
  import edge_detect_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // edge enable registers
  logic [7:0] rising_edge_enable_r;
  logic [7:0] falling_edge_enable_r;
  logic [7:0] rising_edge_enable_nxt;
  logic [7:0] falling_edge_enable_nxt;
  logic [7:0] rdata_nxt;

  wire sel_rise = (ADDR == RISE_EN_ADDR);
  wire sel_fall = (ADDR == FALL_EN_ADDR);
  wire [7:0] bit_mask = 8'h01 << BIT_SEL;
  // a bit operation touches only the chosen bit of the old value
  wire [7:0] rise_bitw = (rising_edge_enable_r & ~bit_mask)
                       | ({8{WDATA[0]}} & bit_mask);
  wire [7:0] fall_bitw = (falling_edge_enable_r & ~bit_mask)
                       | ({8{WDATA[0]}} & bit_mask);
  wire [7:0] rise_wval = BIT_OP ? rise_bitw : WDATA;
  wire [7:0] fall_wval = BIT_OP ? fall_bitw : WDATA;
  assign rising_edge_enable_nxt = (WR & sel_rise)
      ? (rise_wval & EN_USED_MASK) : rising_edge_enable_r;
  assign falling_edge_enable_nxt = (WR & sel_fall)
      ? (fall_wval & EN_USED_MASK) : falling_edge_enable_r;
  wire [7:0] rd_word = sel_rise ? rising_edge_enable_r
                     : sel_fall ? falling_edge_enable_r : 8'h00;
  // bit read returns the addressed bit in bit 0
  wire [7:0] rd_bit = {7'h00, rd_word[BIT_SEL]};
  assign rdata_nxt = RD ? (BIT_OP ? rd_bit : rd_word) : 8'h00;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rising_edge_enable_r  <= EN_RESET;
      falling_edge_enable_r <= EN_RESET;
      RDATA                 <= 8'h00;
    end else if (CE) begin
      rising_edge_enable_r  <= rising_edge_enable_nxt;
      falling_edge_enable_r <= falling_edge_enable_nxt;
      RDATA                 <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin edge detection; no standby input exists, but it freezes while CE is low
  wire [NUM_PINS-1:0] pins = {PORT_PIN_C, PORT_PIN_B, PORT_PIN_A};
  wire [NUM_PINS-1:0] rise_sel = {rising_edge_enable_r[PIN_C_BIT],
                                  rising_edge_enable_r[PIN_B_BIT],
                                  rising_edge_enable_r[PIN_A_BIT]};
  wire [NUM_PINS-1:0] fall_sel = {falling_edge_enable_r[PIN_C_BIT],
                                  falling_edge_enable_r[PIN_B_BIT],
                                  falling_edge_enable_r[PIN_A_BIT]};
  wire [NUM_PINS-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      pin_edge_unit u_edge (
        .clk  (CORE_CLK),
        .rst  (RST),
        .ce   (CE),
        .pin  (pins[g]),
        .mode (edge_mode_t'({rise_sel[g], fall_sel[g]})),
        .hit  (hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // request outputs with fixed identity of the lowest numbered hit
  logic [2:0]  prio_nxt;
  logic [15:0] vec_nxt;
  logic [19:0] mscw_nxt;
  // simultaneous hits: lowest default number wins for the id outputs;
  // masking and the four programmable levels live in the interrupt controller
  assign prio_nxt = hit[0] ? DEF_PRIO_A : hit[1] ? DEF_PRIO_B
                  : hit[2] ? DEF_PRIO_C : 3'h0;
  assign vec_nxt  = hit[0] ? VECTOR_A : hit[1] ? VECTOR_B
                  : hit[2] ? VECTOR_C : 16'h0000;
  assign mscw_nxt = hit[0] ? MSCW_A : hit[1] ? MSCW_B
                  : hit[2] ? MSCW_C : 20'h0_0000;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      EXT_IRQ_A    <= 1'b0;
      EXT_IRQ_B    <= 1'b0;
      EXT_IRQ_C    <= 1'b0;
      IRQ_DEF_PRIO <= 3'h0;
      IRQ_VECTOR   <= 16'h0000;
      IRQ_MSCW     <= 20'h0_0000;
    end else if (CE) begin
      EXT_IRQ_A    <= hit[0];
      EXT_IRQ_B    <= hit[1];
      EXT_IRQ_C    <= hit[2];
      IRQ_DEF_PRIO <= prio_nxt;
      IRQ_VECTOR   <= vec_nxt;
      IRQ_MSCW     <= mscw_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== ext_pins.sv
`timescale 1ns/1ps
`default_nettype none
module ext_pins (
  output var logic [2:0] pins
);
  // pins are plain driven levels, no pull; the bench changes them off-edge
  initial pins = 3'h0;
  task drive(input logic [2:0] v);
    pins = v;
  endtask
endmodule
`default_nettype wire

// ===== edge_detect_sva.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect_sva (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        RD,
  input wire logic        BIT_OP,
  input wire logic [7:0]  RDATA,
  input wire logic        EXT_IRQ_A,
  input wire logic        EXT_IRQ_B,
  input wire logic        EXT_IRQ_C,
  input wire logic [2:0]  IRQ_DEF_PRIO,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic [19:0] IRQ_MSCW
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_rst; $past(RST) |-> RDATA == 8'h00 && !EXT_IRQ_A; endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_idle; $past(CE) && !$past(RD) |-> RDATA == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata idle");
  property p_unused;
    $past(RD) && $past(CE) && !$past(BIT_OP) |-> (RDATA & 8'h4f) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit");
  property p_bit; $past(RD) && $past(BIT_OP) |-> RDATA[7:1] == 7'h00; endproperty
  a_bit: assert property (p_bit) else $error("bit read");
  property p_once; EXT_IRQ_A && CE |=> !EXT_IRQ_A; endproperty
  a_once: assert property (p_once) else $error("long pulse");
  property p_pa; EXT_IRQ_A |-> IRQ_DEF_PRIO == 3'h1 &&
    IRQ_VECTOR == 16'h0008 && IRQ_MSCW == 20'h0_fe08; endproperty
  a_pa: assert property (p_pa) else $error("pin a id");
  property p_pb; EXT_IRQ_B && !EXT_IRQ_A |-> IRQ_DEF_PRIO == 3'h2 &&
    IRQ_VECTOR == 16'h000a && IRQ_MSCW == 20'h0_fe0a; endproperty
  a_pb: assert property (p_pb) else $error("pin b id");
  property p_pc; EXT_IRQ_C && !EXT_IRQ_A && !EXT_IRQ_B |->
    IRQ_DEF_PRIO == 3'h3 && IRQ_VECTOR == 16'h000c &&
    IRQ_MSCW == 20'h0_fe0c; endproperty
  a_pc: assert property (p_pc) else $error("pin c id");
  property p_none; !(EXT_IRQ_A || EXT_IRQ_B || EXT_IRQ_C) |->
    IRQ_DEF_PRIO == 3'h0 && IRQ_VECTOR == 16'h0000 &&
    IRQ_MSCW == 20'h0_0000; endproperty
  a_none: assert property (p_none) else $error("stray id");
endmodule
bind edge_detect edge_detect_sva i_edge_detect_sva (.*);
`default_nettype wire

// ===== edge_detect_test.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect_test;
  import edge_detect_pkg::*;
  logic CORE_CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, BIT_OP = 0;
  logic EXT_IRQ_A, EXT_IRQ_B, EXT_IRQ_C;
  logic [2:0]  BIT_SEL = 3'h0, pins, IRQ_DEF_PRIO;
  logic [15:0] ADDR = 16'h0000, IRQ_VECTOR;
  logic [7:0]  WDATA = 8'h00, RDATA, q, cnt [3];
  logic [19:0] IRQ_MSCW;
  int num_errors = 0, n_tests = 0, cyc = 0;
  edge_detect i_edge_detect (.PORT_PIN_A(pins[0]), .PORT_PIN_B(pins[1]),
    .PORT_PIN_C(pins[2]), .*);
  ext_pins i_ext_pins (.pins(pins));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  // pulses are counted, so a doubled pulse is caught as well as a missing one
  always @(posedge CORE_CLK) begin
    cnt[0] <= cnt[0] + EXT_IRQ_A;
    cnt[1] <= cnt[1] + EXT_IRQ_B;
    cnt[2] <= cnt[2] + EXT_IRQ_C;
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      end_of_test();
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic b,
           input logic [2:0] s, input logic [7:0] d);
    @(posedge CORE_CLK) #1;
    {WR, RD, ADDR, BIT_OP, BIT_SEL, WDATA} = {w, !w, a, b, s, d};
    @(posedge CORE_CLK) #1;
    {WR, RD} = 2'h0;
    q = RDATA;
  endtask
  task tst(input logic [7:0] r, input logic [7:0] f,
           input logic [2:0] er, input logic [2:0] ef);
    acc(1, RISE_EN_ADDR, 0, 0, r);
    acc(1, FALL_EN_ADDR, 0, 0, f);
    acc(0, FALL_EN_ADDR, 0, 0, 0);
    chk("fall_en", f, q);
    for (int p = 0; p < 2; p++) begin
      foreach (cnt[i]) cnt[i] = 8'h00;
      i_ext_pins.drive({3{p == 0}});
      repeat (8) @(posedge CORE_CLK);
      #1;
      for (int i = 0; i < 3; i++) chk("irq", {7'h0, p ? ef[i] : er[i]}, cnt[i]);
    end
  endtask
  task end_of_test();
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge CORE_CLK);
    #1;
    RST = 0;
    acc(0, RISE_EN_ADDR, 0, 0, 0);
    chk("rise_rst", 8'h00, q);
    acc(0, FALL_EN_ADDR, 0, 0, 0);
    chk("fall_rst", 8'h00, q);
    acc(1, RISE_EN_ADDR, 0, 0, 8'hff);
    acc(1, RISE_EN_ADDR, 1, 3'h7, 8'h00);
    acc(1, RISE_EN_ADDR, 1, 3'h6, 8'h01);
    acc(0, RISE_EN_ADDR, 0, 0, 0);
    chk("rise_byte", 8'h30, q);
    acc(0, RISE_EN_ADDR, 1, 3'h5, 0);
    chk("rise_bit", 8'h01, q);
    acc(1, 16'hffa1, 0, 0, 8'hff);
    acc(0, 16'hffa1, 0, 0, 0);
    chk("unmapped", 8'h00, q);
    // clock enable low must freeze the register, so this write is lost
    CE = 0;
    acc(1, RISE_EN_ADDR, 0, 0, 8'h00);
    CE = 1;
    acc(0, RISE_EN_ADDR, 0, 0, 0);
    chk("frozen", 8'h30, q);
    tst(8'h00, 8'h00, 3'h0, 3'h0);
    tst(8'h00, 8'hb0, 3'h0, 3'h7);
    tst(8'hb0, 8'hb0, 3'h7, 3'h7);
    tst(8'h10, 8'h00, 3'h1, 3'h0);
    tst(8'h20, 8'h00, 3'h2, 3'h0);
    tst(8'hb0, 8'h80, 3'h7, 3'h4);
    end_of_test();
  end
endmodule
`default_nettype wire
